// File: rtl/port_expander_pkg.sv
package port_expander_pkg;
    // Register indices carried by the two low command bits
    localparam logic [1:0] REG_INPUT_LEVELS  = 2'h0;
    localparam logic [1:0] REG_OUTPUT_LATCH  = 2'h1;
    localparam logic [1:0] REG_INVERT_MASK   = 2'h2;
    localparam logic [1:0] REG_DIRECTION     = 2'h3;
    // Reset values
    localparam logic [7:0] OUTPUT_LATCH_RST  = 8'hff;
    localparam logic [7:0] INVERT_MASK_RST   = 8'h00;
    localparam logic [7:0] DIRECTION_RST     = 8'hff;
    // Fixed upper four address bits, low-high-high-high
    localparam logic [3:0] ADDR_FIXED_HIGH   = 4'h7;
    // Direction bit in the address byte
    localparam logic       DIR_READ          = 1'b1;
    // Link clock divider: half period in core clocks (100 MHz / 40 = 2.5 MHz)
    localparam int         CORE_CLK_MHZ      = 100;
    localparam int         LINK_HALF_NS      = 200;
    localparam int         LINK_HALF_CYC     = (LINK_HALF_NS * CORE_CLK_MHZ) / 1000;
    // Master commands
    typedef enum logic [1:0] {
        CMD_WRITE  = 2'b00,
        CMD_READ   = 2'b01,
        CMD_SETPTR = 2'b10
    } master_cmd_t;
endpackage

// File: rtl/expander_link_if.sv
interface expander_link_if;
    // Clock line: only the master drives it
    logic sclOut;
    logic sclOe;
    // Data line, open drain on both ends; enable low means pulling low
    logic sdaDevOut;
    logic sdaDevOeN;
    logic sdaMstOut;
    logic sdaMstOeN;
    // Interrupt, open drain, active low
    logic alertOut;
    logic alertOeN;
    // Wire levels resolved from enables with pull-ups
    logic scl;
    logic sda;
    logic alertN;
    assign scl    = sclOe ? sclOut : 1'b1;
    assign sda    = (!sdaDevOeN && !sdaDevOut) || (!sdaMstOeN && !sdaMstOut) ? 1'b0 : 1'b1;
    assign alertN = (!alertOeN && !alertOut) ? 1'b0 : 1'b1;
    modport device (input scl, input sda, output sdaDevOut, output sdaDevOeN,
                    output alertOut, output alertOeN);
    modport master (input scl, input sda, input alertN, output sclOut, output sclOe,
                    output sdaMstOut, output sdaMstOeN);
endinterface

// File: rtl/sync_edge.sv
// Two-stage synchroniser with edge flags taken from the second stage
module sync_edge (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic asyncIn,
    output logic      syncOut,
    output logic      rise,
    output logic      fall
);
    logic metaReg;   // First stage, read only by the second
    logic syncReg;   // Second stage
    logic lastReg;   // Previous synchronised level

    // Idle bus level is high, so reset to one
    always_ff @(posedge core_clk) begin
        if (reset) begin
            metaReg <= 1'b1;
            syncReg <= 1'b1;
            lastReg <= 1'b1;
        end else begin
            metaReg <= asyncIn;
            syncReg <= metaReg;
            lastReg <= syncReg;
        end
    end
    assign syncOut = syncReg;
    assign rise    = syncReg & ~lastReg;
    assign fall    = ~syncReg & lastReg;
endmodule

// File: rtl/expander_device.sv
module expander_device
    import port_expander_pkg::*;
#(
    parameter int PINS = 8
) (
    input  wire logic            core_clk,
    input  wire logic            reset,
    expander_link_if.device      link,
    input  wire logic            addr_select_bit0,
    input  wire logic            addr_select_bit1,
    input  wire logic            addr_select_bit2,
    input  wire logic [PINS-1:0] portPinsIn,
    output logic      [PINS-1:0] portPinsOut,
    output logic      [PINS-1:0] portPinsOeN
);
    // Bus receiver states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ADDR   = 3'b001,
        ST_ACK    = 3'b010,
        ST_WRITE  = 3'b011,
        ST_READ   = 3'b100,
        ST_RDACK  = 3'b101,
        ST_IGNORE = 3'b110
    } bus_state_t;

    logic            sclS, sclRise, sclFall;   // Synchronised clock line
    logic            sdaS, sdaRise, sdaFall;   // Synchronised data line
    logic [PINS-1:0] pinMeta, pinSync;         // Pin synchroniser stages
    logic [2:0]      addrMeta, addrSync;       // Address pin synchroniser
    bus_state_t      state_reg;                // Receiver state
    logic [7:0]      shift_reg;                // Byte shifter
    logic [3:0]      bitCnt_reg;               // Bits seen in current byte
    logic            isRead_reg;               // Current transfer direction
    logic            gotCmd_reg;               // Command byte already taken
    logic            ackDrive_reg;             // Pulling data low for ack
    logic [1:0]      ptr_reg;                  // Register pointer
    logic [7:0]      latch_reg, invert_reg, dir_reg;
    logic [PINS-1:0] snap_reg;                 // Level seen at last clear
    logic            alert_reg;                // Interrupt pending
    logic [7:0]      inputView;                // Pin level after inversion
    logic [7:0]      readData;                 // Selected register value
    logic            startCond, stopCond;
    logic            addrMatch;
    logic            readAckEdge;              // Rising clock of read ack bit

    sync_edge u_scl (.core_clk(core_clk), .reset(reset), .asyncIn(link.scl),
                     .syncOut(sclS), .rise(sclRise), .fall(sclFall));
    sync_edge u_sda (.core_clk(core_clk), .reset(reset), .asyncIn(link.sda),
                     .syncOut(sdaS), .rise(sdaRise), .fall(sdaFall));

    // Pins and straps come from outside, two stages first
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pinMeta  <= '0;
            pinSync  <= '0;
            addrMeta <= 3'h0;
            addrSync <= 3'h0;
        end else begin
            pinMeta  <= portPinsIn;
            pinSync  <= pinMeta;
            addrMeta <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};
            addrSync <= addrMeta;
        end
    end

    // Start and stop are data edges while clock is high
    assign startCond = sdaFall & sclS;
    assign stopCond  = sdaRise & sclS;
    // Fixed high nibble plus strap bits; after eight bits the direction sits in bit 0
    assign addrMatch = shift_reg[7:1] == {ADDR_FIXED_HIGH, addrSync};
    assign inputView = pinSync ^ invert_reg;

    // Register read mux; pointer bits only
    always_comb begin
        case (ptr_reg)
            REG_INPUT_LEVELS: readData = inputView;
            REG_OUTPUT_LATCH: readData = latch_reg;
            REG_INVERT_MASK:  readData = invert_reg;
            REG_DIRECTION:    readData = dir_reg;
            default:          readData = 8'h00;
        endcase
    end

    // Bus receiver: bits sampled on clock rise, data changed on clock fall
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg    <= ST_IDLE;
            shift_reg    <= 8'h00;
            bitCnt_reg   <= 4'h0;
            isRead_reg   <= 1'b0;
            gotCmd_reg   <= 1'b0;
            ackDrive_reg <= 1'b0;
            ptr_reg      <= REG_INPUT_LEVELS;
            latch_reg    <= OUTPUT_LATCH_RST;
            invert_reg   <= INVERT_MASK_RST;
            dir_reg      <= DIRECTION_RST;
        end else if (startCond) begin
            // Repeated start also lands here; pointer kept
            state_reg    <= ST_ADDR;
            bitCnt_reg   <= 4'h0;
            ackDrive_reg <= 1'b0;
            gotCmd_reg   <= 1'b0;
        end else if (stopCond) begin
            state_reg    <= ST_IDLE;
            ackDrive_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE, ST_IGNORE: begin
                    // Foreign traffic: nothing moves
                    ackDrive_reg <= 1'b0;
                end
                ST_ADDR: begin
                    if (sclRise) begin
                        shift_reg  <= {shift_reg[6:0], sdaS};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end
                    if (sclFall && bitCnt_reg == 4'h8) begin
                        if (addrMatch) begin
                            isRead_reg   <= shift_reg[0] == DIR_READ;
                            ackDrive_reg <= 1'b1;
                            state_reg    <= ST_ACK;
                        end else begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
                ST_ACK: begin
                    // Release after the ack pulse falls
                    if (sclFall) begin
                        ackDrive_reg <= 1'b0;
                        bitCnt_reg   <= 4'h0;
                        if (isRead_reg) begin
                            shift_reg <= readData;
                            state_reg <= ST_READ;
                        end else begin
                            state_reg <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (sclRise) begin
                        shift_reg  <= {shift_reg[6:0], sdaS};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end
                    if (sclFall && bitCnt_reg == 4'h8) begin
                        ackDrive_reg <= 1'b1;
                        state_reg    <= ST_ACK;
                        if (!gotCmd_reg) begin
                            ptr_reg    <= shift_reg[1:0];
                            gotCmd_reg <= 1'b1;
                        end else begin
                            // Data bytes, unlimited count, input register ignored
                            case (ptr_reg)
                                REG_OUTPUT_LATCH: latch_reg  <= shift_reg;
                                REG_INVERT_MASK:  invert_reg <= shift_reg;
                                REG_DIRECTION:    dir_reg    <= shift_reg;
                                default:          ;
                            endcase
                        end
                    end
                end
                ST_READ: begin
                    if (sclFall) begin
                        if (bitCnt_reg == 4'h7) begin
                            state_reg <= ST_RDACK;
                        end else begin
                            shift_reg  <= {shift_reg[6:0], 1'b0};
                            bitCnt_reg <= bitCnt_reg + 4'h1;
                        end
                    end
                end
                ST_RDACK: begin
                    // Next byte captured at rising edge of ack bit
                    if (sclRise) begin
                        shift_reg <= readData;
                    end
                    if (sclFall) begin
                        bitCnt_reg <= 4'h0;
                        state_reg  <= sdaS ? ST_IGNORE : ST_READ;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign readAckEdge = (state_reg == ST_RDACK) && sclRise;

    // Interrupt: compare input-mode pins to snapshot taken at last clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            snap_reg  <= '0;
            alert_reg <= 1'b0;
        end else if (readAckEdge) begin
            // Clear wins here: a change up to the ack rising edge is absorbed
            snap_reg  <= pinSync;
            alert_reg <= 1'b0;
        end else begin
            // Difference on input pins only; level back means clear
            alert_reg <= |((pinSync ^ snap_reg) & dir_reg);
        end
    end

    // Pin drivers: direction zero drives the latch
    assign portPinsOut = latch_reg;
    assign portPinsOeN = dir_reg;

    // Open-drain data and interrupt: only ever pull low
    assign link.sdaDevOut = 1'b0;
    assign link.sdaDevOeN = ~(ackDrive_reg | (state_reg == ST_READ && !shift_reg[7]));
    assign link.alertOut  = 1'b0;
    assign link.alertOeN  = ~alert_reg;
endmodule

// File: rtl/expander_master.sv
// Bus master: issues write, pointer set, or read of one register
module expander_master
    import port_expander_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    expander_link_if.master link,
    input  wire logic [2:0] devAddr,
    input  wire logic       cmdValid,
    input  master_cmd_t     cmdKind,
    input  wire logic [1:0] cmdReg,
    input  wire logic [7:0] cmdData,
    output logic            cmdReady,
    output logic            done,
    output logic            acked,
    output logic [7:0]      rdData,
    output logic            alertSeen
);
    typedef enum logic [2:0] {
        M_IDLE  = 3'b000,
        M_START = 3'b001,
        M_BITS  = 3'b010,
        M_STOP  = 3'b011,
        M_DONE  = 3'b100
    } mst_state_t;

    mst_state_t  state_reg;
    logic [7:0]  div_reg;          // Quarter-period divider
    logic [1:0]  phase_reg;        // Quarter phase of a bit
    logic [5:0]  bit_reg;          // Bit index within whole frame
    logic [5:0]  total_reg;        // Frame length in bits
    logic [35:0] tx_reg;           // Bits to send, 1 = release
    logic [35:0] rdMask_reg;       // Bits read back
    logic        scl_reg, sda_reg, acked_reg;
    logic [7:0]  rd_reg;
    logic        alertMeta, alertSync;
    logic        tick;
    logic [6:0]  addr7;

    assign addr7 = {ADDR_FIXED_HIGH, devAddr};
    assign tick  = div_reg == 8'(LINK_HALF_CYC / 2 - 1);

    // Alert pin is asynchronous to this end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            alertMeta <= 1'b1;
            alertSync <= 1'b1;
        end else begin
            alertMeta <= link.alertN;
            alertSync <= alertMeta;
        end
    end

    // Frame sequencer; a read frame uses the pointer left by the last command
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= M_IDLE;
            div_reg   <= 8'h00;
            phase_reg <= 2'h0;
            bit_reg   <= 6'h00;
            total_reg <= 6'h00;
            tx_reg    <= '1;
            rdMask_reg<= '0;
            scl_reg   <= 1'b1;
            sda_reg   <= 1'b1;
            acked_reg <= 1'b1;
            rd_reg    <= 8'h00;
        end else begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
            case (state_reg)
                M_IDLE: if (cmdValid) begin
                    acked_reg <= 1'b1;
                    bit_reg   <= 6'h00;
                    phase_reg <= 2'h0;
                    state_reg <= M_START;
                    rdMask_reg <= '0;
                    case (cmdKind)
                        CMD_WRITE: begin
                            tx_reg    <= {addr7, 1'b0, 1'b1, 6'h00, cmdReg, 1'b1,
                                          cmdData, 1'b1, 9'h1ff};
                            total_reg <= 6'h1b;
                        end
                        CMD_SETPTR: begin
                            tx_reg    <= {addr7, 1'b0, 1'b1, 6'h00, cmdReg, 1'b1, 18'h3ffff};
                            total_reg <= 6'h12;
                        end
                        default: begin
                            // Read: address with read bit, then data, NACK last
                            tx_reg     <= {addr7, DIR_READ, 1'b1, 8'hff, 1'b1, 18'h3ffff};
                            rdMask_reg <= {9'h000, 8'hff, 1'b0, 18'h00000};
                            total_reg  <= 6'h12;
                        end
                    endcase
                end
                M_START: if (tick) begin
                    sda_reg   <= 1'b0;
                    state_reg <= M_BITS;
                end
                M_BITS: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    case (phase_reg)
                        2'h0: begin
                            scl_reg <= 1'b0;
                        end
                        2'h1: sda_reg <= tx_reg[35];
                        2'h2: scl_reg <= 1'b1;
                        default: begin
                            if (rdMask_reg[35]) begin
                                rd_reg <= {rd_reg[6:0], link.sda};
                            end
                            if (bit_reg == 6'h08 && link.sda) begin
                                acked_reg <= 1'b0;
                            end
                            tx_reg     <= {tx_reg[34:0], 1'b1};
                            rdMask_reg <= {rdMask_reg[34:0], 1'b0};
                            bit_reg    <= bit_reg + 6'h01;
                            if (bit_reg + 6'h01 == total_reg) begin
                                state_reg <= M_STOP;
                            end
                        end
                    endcase
                end
                M_STOP: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    case (phase_reg)
                        2'h0: scl_reg <= 1'b0;
                        2'h1: sda_reg <= 1'b0;
                        2'h2: scl_reg <= 1'b1;
                        default: begin
                            sda_reg   <= 1'b1;
                            state_reg <= M_DONE;
                        end
                    endcase
                end
                default: state_reg <= M_IDLE;
            endcase
        end
    end

    assign cmdReady       = state_reg == M_IDLE;
    assign done           = state_reg == M_DONE;
    assign acked          = acked_reg;
    assign rdData         = rd_reg;
    assign alertSeen      = ~alertSync;
    assign link.sclOut    = scl_reg;
    assign link.sclOe     = 1'b1;
    assign link.sdaMstOut = 1'b0;
    assign link.sdaMstOeN = sda_reg;
endmodule

// File: tb/expander_link_props.sv
module expander_link_props
    import port_expander_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda,
    input wire logic sdaDevOut,
    input wire logic sdaDevOeN,
    input wire logic alertOut,
    input wire logic alertOeN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       sclQ;     // Clock line one cycle ago
    logic       sdaQ;     // Data line one cycle ago
    logic [3:0] bitCnt;   // Bit within byte, 8 is the ack slot
    logic [3:0] byteCnt;  // Bytes since the last start
    logic [7:0] shReg;    // Bits of the byte on the wire
    logic       rdFrame;  // Direction bit of this frame
    logic       hit;      // Address byte was acknowledged
    logic       rise;     // Clock line rising
    logic       ackRise;  // Clock rising in an ack slot
    assign rise    = scl && !sclQ;
    assign ackRise = rise && bitCnt == 4'h8;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Line history for edge finding
    always_ff @(posedge core_clk) begin
        sclQ <= scl;
        sdaQ <= sda;
    end
    // Bit and byte counts; a start condition restarts them
    always_ff @(posedge core_clk) begin
        if (reset || (scl && sclQ && sdaQ && !sda)) begin
            bitCnt  <= 4'h0;
            byteCnt <= 4'h0;
        end else if (ackRise) begin
            bitCnt  <= 4'h0;
            byteCnt <= byteCnt + 4'h1;
        end else if (rise) begin
            bitCnt  <= bitCnt + 4'h1;
            shReg   <= {shReg[6:0], sda};
        end
    end
    // Direction and match, caught once per frame; unknown until the first frame
    always_ff @(posedge core_clk) begin
        if (rise && byteCnt == 4'h0 && bitCnt == 4'h7) rdFrame <= sda;
        if (ackRise && byteCnt == 4'h0) hit <= !sda;
    end
    // Device data drive must sit still for eight cycles after the clock rises
    sequence holdHigh;
        $stable(sdaDevOeN) [*8];
    endsequence
    // Interrupt let go shortly after the read ack edge, sync lag included
    sequence alertLetGo;
        ##[1:8] alertOeN;
    endsequence
    AST_SDA_OPEN_DRAIN: assert property (!sdaDevOeN |-> !sdaDevOut)
        else $error("device drives the data line high");
    AST_ALERT_OPEN_DRAIN: assert property (!alertOeN |-> !alertOut)
        else $error("interrupt driven high");
    AST_RESET_IDLE: assert property ($fell(reset) |-> sdaDevOeN && alertOeN)
        else $error("lines not released after reset");
    AST_QUIET_AT_CONDITION: assert property (scl && sclQ && $changed(sda) |-> sdaDevOeN && $past(sdaDevOeN))
        else $error("device on data line at start or stop");
    AST_HOLD_WHILE_HIGH: assert property (rise |-> holdHigh)
        else $error("device data moved while clock high");
    AST_ADDR_PATTERN: assert property (ackRise && byteCnt == 4'h0 && !sdaDevOeN |-> shReg[7:4] == ADDR_FIXED_HIGH)
        else $error("device acknowledged a foreign address");
    AST_WRITE_ACK: assert property (ackRise && byteCnt != 4'h0 && hit && !rdFrame |-> !sdaDevOeN)
        else $error("written byte not acknowledged");
    AST_READ_CLEAR: assert property (ackRise && byteCnt != 4'h0 && hit && rdFrame |-> alertLetGo)
        else $error("interrupt not cleared by read");
endmodule

// File: tb/i2c_eight_bit_port_expander_test.sv
module i2c_eight_bit_port_expander_test
    import port_expander_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, reset;           // Clock and synchronous reset
    logic [2:0]  strap, devAddr;            // Device straps, master target
    logic        cmdValid, cmdReady, done;  // Master request handshake
    master_cmd_t cmdKind;                   // Request kind
    logic [1:0]  cmdReg;                    // Register index
    logic [7:0]  cmdData, rdData;           // Write byte, read byte
    logic        acked, alertSeen;          // Master status
    logic [7:0]  extPins, pinOut, pinOeN;   // Outside level, device drive
    logic [7:0]  pinLvl;                    // Resolved pin level
    int          miscompares, samples_checked, cycles;
    expander_link_if link ();
    // Driven pins win, the rest follow the outside level
    assign pinLvl = (pinOut & ~pinOeN) | (extPins & pinOeN);
    expander_device expander_device_inst (.core_clk(core_clk), .reset(reset), .link(link),
        .addr_select_bit0(strap[0]), .addr_select_bit1(strap[1]), .addr_select_bit2(strap[2]),
        .portPinsIn(pinLvl), .portPinsOut(pinOut), .portPinsOeN(pinOeN));
    expander_master expander_master_inst (.core_clk(core_clk), .reset(reset), .link(link),
        .devAddr(devAddr), .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdReg(cmdReg),
        .cmdData(cmdData), .cmdReady(cmdReady), .done(done), .acked(acked),
        .rdData(rdData), .alertSeen(alertSeen));
    expander_link_props expander_link_props_inst (.core_clk(core_clk), .reset(reset),
        .scl(link.scl), .sda(link.sda), .sdaDevOut(link.sdaDevOut),
        .sdaDevOeN(link.sdaDevOeN), .alertOut(link.alertOut), .alertOeN(link.alertOeN));
    // Free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic results();
        $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // A hung frame would stall forever; cut it short here
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            results();
        end
    end
    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] act);
        samples_checked++;
        if (act !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, act);
            miscompares++;
        end
    endtask
    // One master frame: request for a single edge, then wait for its end pulse
    task automatic xfer(input master_cmd_t k, input logic [1:0] r, input logic [7:0] d);
        @(negedge core_clk);
        cmdValid = 1'b1;
        cmdKind  = k;
        cmdReg   = r;
        cmdData  = d;
        @(negedge core_clk);
        cmdValid = 1'b0;
        while (done !== 1'b1) @(negedge core_clk);
    endtask
    // Pointer write, then a separate read frame
    task automatic rd(input logic [1:0] r, input logic [7:0] exp, input string nm);
        xfer(CMD_SETPTR, r, 8'h00);
        xfer(CMD_READ, r, 8'h00);
        check(nm, exp, rdData);
    endtask
    // Interrupt passes two synchronisers; allow it to settle
    task automatic alertAfter(input logic exp, input string nm);
        repeat (20) @(negedge core_clk);
        check(nm, {7'h00, exp}, {7'h00, alertSeen});
    endtask
    initial begin
        {reset, cmdValid, cmdReg, cmdData, extPins} = {1'b1, 1'b0, 2'h0, 8'h00, 8'h00};
        {strap, devAddr} = {3'h5, 3'h5};
        miscompares = 0;
        samples_checked = 0;
        cmdKind = CMD_WRITE;
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        check("pin enables at reset", 8'hff, pinOeN);
        check("master idle", 8'h01, {7'h00, cmdReady});
        rd(REG_OUTPUT_LATCH, 8'hff, "latch reset");
        rd(REG_INVERT_MASK, 8'h00, "invert reset");
        rd(REG_DIRECTION, 8'hff, "direction reset");
        alertAfter(1'b0, "alert idle");
        $display("Test defaults done");
        extPins = 8'h01;
        alertAfter(1'b1, "alert on rise");
        // Sweep every target address; only the one matching strap 5 may answer
        for (int a = 0; a < 8; a++) begin
            devAddr = a[2:0];
            xfer(CMD_SETPTR, REG_INPUT_LEVELS, 8'h00);
            check("address ack", {7'h00, a == 5}, {7'h00, acked});
        end
        devAddr = 3'h5;
        alertAfter(1'b1, "alert kept over traffic");
        rd(REG_INPUT_LEVELS, 8'h01, "input level");
        alertAfter(1'b0, "alert cleared by read");
        extPins = 8'h00;
        alertAfter(1'b1, "alert on fall");
        extPins = 8'h01;
        alertAfter(1'b0, "alert on return");
        $display("Test address and interrupt done");
        xfer(CMD_WRITE, REG_OUTPUT_LATCH, 8'h5a);
        xfer(CMD_WRITE, REG_INVERT_MASK, 8'h0f);
        xfer(CMD_WRITE, REG_DIRECTION, 8'h0f);
        check("pin enables", 8'h0f, pinOeN);
        check("driven pins", 8'h50, pinLvl & 8'hf0);
        check("input pins undriven", 8'h01, pinLvl & 8'h0f);
        alertAfter(1'b0, "outputs raise no alert");
        rd(REG_OUTPUT_LATCH, 8'h5a, "latch readback");
        rd(REG_INVERT_MASK, 8'h0f, "invert readback");
        rd(REG_DIRECTION, 8'h0f, "direction readback");
        $display("Test registers done");
        extPins = 8'h0c;
        rd(REG_INPUT_LEVELS, 8'h53, "inverted input");
        xfer(CMD_WRITE, REG_INPUT_LEVELS, 8'hff);
        xfer(CMD_READ, REG_INPUT_LEVELS, 8'h00);
        check("input after write", 8'h53, rdData);
        xfer(CMD_SETPTR, REG_OUTPUT_LATCH, 8'h00);
        // Reads alone must keep the pointer where the write left it
        for (int i = 0; i < 2; i++) begin
            xfer(CMD_READ, REG_INPUT_LEVELS, 8'h00);
            check("pointer kept", 8'h5a, rdData);
        end
        // Upper pins go back to inputs at a level unlike the last snapshot
        xfer(CMD_WRITE, REG_DIRECTION, 8'hff);
        alertAfter(1'b1, "alert on direction change");
        $display("Test input and pointer done");
        results();
    end
endmodule
